/* File: rtl/rce_map.vh */
/*
  Opcode patterns, pc/sp step sizes and reset values for the repeat and
  computed-call execution block.
  Assumes it is included by bare name from rtl/ design files.
*/
`ifndef RCE_MAP_VH
`define RCE_MAP_VH
`define RCE_OP_CALLW 20'h01200
`define RCE_OP_CALLW_X 20'h01020
`define RCE_OP_REPL_B 10'h024
`define RCE_OP_REPL_X 9'h012
`define RCE_OP_REPW 20'h09800
`define RCE_OP_RESET 24'hFE0000
`define RCE_NOP 24'h000000
`define RCE_PC_STEP 23'h000002
`define RCE_PC_RST 23'h000000
`define RCE_SP_RST 16'h0800
`define RCE_SP_STEP 16'h0002
`define RCE_RC_RST 16'h0000
`endif

/* File: rtl/rce_dec.v */
/*
  Opcode classifier for the repeat and computed-call block.
  Assumes a registered 24-bit instruction word at its input.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rce_map.vh"
module rce_dec (
  input wire [23:0] instr,
  input wire ext_mode,
  output wire is_callw,
  output wire is_repl,
  output wire is_repw,
  output wire is_reset,
  output wire [3:0] reg_sel,
  output wire [14:0] lit
);
  // -----------------------------
  // decode
  // -----------------------------
  // register-direct only: selector is just the low nibble
  assign is_callw = ext_mode ? (instr[23:4] == `RCE_OP_CALLW_X) :
                    (instr[23:4] == `RCE_OP_CALLW);
  assign is_repl = ext_mode ? (instr[23:15] == `RCE_OP_REPL_X) :
                   (instr[23:14] == `RCE_OP_REPL_B);
  assign is_repw = (instr[23:4] == `RCE_OP_REPW);
  assign is_reset = (instr == `RCE_OP_RESET);
  assign reg_sel = instr[3:0];
  assign lit = ext_mode ? instr[14:0] : {1'b0, instr[13:0]};
endmodule // rce_dec
`default_nettype wire

/* File: rtl/rce_exec.v */
/*
  Execution of computed relative call, repeat (literal and register)
  and software reset inside a 16-bit core.
  Assumes the fetch unit supplies one instruction per instr_valid pulse,
  honours fetch_hold, and that the working-register file answers
  reg_rdata combinationally from reg_sel. Stack writes go out one word
  per cycle on the stack port.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rce_map.vh"
module rce_exec #(
  parameter EXT = 1'b0
) (
  input wire clk,
  input wire nrst,
  input wire instr_valid,
  input wire [23:0] instr_in,
  input wire [15:0] reg_rdata,
  input wire sfa_in,
  output wire [3:0] reg_sel,
  output reg [22:0] pc_ff,
  output reg [15:0] sp_ff,
  output reg [15:0] repeat_counter_ff,
  output reg repeat_active_flag_ff,
  output reg stack_frame_active_flag_ff,
  output reg software_reset_flag_ff,
  output reg stack_we_ff,
  output reg [15:0] stack_addr_ff,
  output reg [15:0] stack_wdata_ff,
  output reg [23:0] ireg_ff,
  output reg target_exec_ff,
  output wire fetch_hold,
  output wire busy
);
  // -----------------------------
  // states
  // -----------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_PUSH2 = 4'b0010;
  localparam [3:0] ST_RPT = 4'b0100;
  localparam [3:0] ST_WAIT = 4'b1000;

  reg [3:0] st_ff;
  reg [3:0] nxt_st;
  reg [22:0] nxt_pc;
  reg [15:0] nxt_sp;
  reg [15:0] nxt_rc;
  reg nxt_ra;
  reg nxt_sfa;
  reg nxt_swr;
  reg nxt_we;
  reg [15:0] nxt_addr;
  reg [15:0] nxt_wdata;
  reg [23:0] nxt_ireg;
  reg nxt_tx;
  reg [22:0] ret_ff;
  reg [22:0] nxt_ret;
  reg [22:0] tgt_ff;
  reg [22:0] nxt_tgt;
  reg sfa_seen_ff;
  reg nxt_sfa_seen;

  wire is_callw;
  wire is_repl;
  wire is_repw;
  wire is_reset;
  wire [14:0] lit;
  wire [22:0] ret_pc;
  wire [22:0] call_tgt;

  rce_dec u_dec (
    .instr(instr_in),
    .ext_mode(EXT),
    .is_callw(is_callw),
    .is_repl(is_repl),
    .is_repw(is_repw),
    .is_reset(is_reset),
    .reg_sel(reg_sel),
    .lit(lit)
  );

  // -----------------------------
  // arithmetic
  // -----------------------------
  // register doubled to 17 bits, then sign-extended to the 23-bit pc
  function [22:0] rel_target;
    input [22:0] base;
    input [15:0] off;
    reg [16:0] dbl;
    begin
      dbl = {off, 1'b0};
      rel_target = base + {{6{dbl[16]}}, dbl};
    end
  endfunction

  assign ret_pc = pc_ff + `RCE_PC_STEP;
  assign call_tgt = rel_target(ret_pc, reg_rdata);
  // while looping the fetch unit must not advance; target stays in ireg
  assign fetch_hold = (st_ff == ST_RPT) || (st_ff == ST_PUSH2);
  assign busy = (st_ff != ST_IDLE);

  // -----------------------------
  // next-state logic
  // -----------------------------
  always @* begin
    nxt_st = st_ff;
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    nxt_rc = repeat_counter_ff;
    nxt_ra = repeat_active_flag_ff;
    nxt_sfa = stack_frame_active_flag_ff;
    nxt_swr = software_reset_flag_ff;
    nxt_we = 1'b0;
    nxt_addr = stack_addr_ff;
    nxt_wdata = stack_wdata_ff;
    nxt_ireg = ireg_ff;
    nxt_tx = 1'b0;
    nxt_ret = ret_ff;
    nxt_tgt = tgt_ff;
    nxt_sfa_seen = sfa_seen_ff;
    case (st_ff)
      ST_IDLE: begin
        if (instr_valid) begin
          nxt_ireg = instr_in;
          if (is_reset) begin
            // pc, sp, repeat counter, repeat and frame flags back to master-clear values; software reset flag set
            nxt_pc = `RCE_PC_RST;
            nxt_sp = `RCE_SP_RST;
            nxt_rc = `RCE_RC_RST;
            nxt_ra = 1'b0;
            nxt_sfa = 1'b0;
            nxt_swr = 1'b1;
          end else if (is_callw) begin
            nxt_we = 1'b1;
            nxt_addr = sp_ff;
            nxt_sp = sp_ff + `RCE_SP_STEP;
            nxt_ret = ret_pc;
            nxt_tgt = call_tgt;
            nxt_sfa_seen = sfa_in;
            nxt_ireg = `RCE_NOP;
            if (EXT) begin
              nxt_wdata = {ret_pc[15:1], stack_frame_active_flag_ff};
            end else begin
              nxt_wdata = ret_pc[15:0];
            end
            nxt_st = ST_PUSH2;
          end else if (is_repl || is_repw) begin
            nxt_pc = ret_pc;
            if (is_repl) begin
              nxt_rc = {1'b0, lit};
            end else if (EXT) begin
              nxt_rc = reg_rdata;
            end else begin
              nxt_rc = {2'b00, reg_rdata[13:0]};
            end
            // zero count: plain no-op, target runs once normally
            if (nxt_rc != `RCE_RC_RST) begin
              nxt_ra = 1'b1;
              nxt_st = ST_WAIT;
            end
          end
        end
      end
      ST_PUSH2: begin
        nxt_we = 1'b1;
        nxt_addr = sp_ff;
        nxt_wdata = {9'h000, ret_ff[22:16]};
        nxt_sp = sp_ff + `RCE_SP_STEP;
        nxt_sfa = 1'b0;
        nxt_pc = tgt_ff;
        nxt_st = ST_IDLE;
      end
      ST_WAIT: begin
        // single fetch of the target, then it is held
        if (instr_valid) begin
          nxt_ireg = instr_in;
          nxt_tx = 1'b1;
          nxt_st = ST_RPT;
        end
      end
      ST_RPT: begin
        nxt_tx = 1'b1;
        // the executing word is ireg_ff; the last pass runs at zero
        if (repeat_counter_ff != `RCE_RC_RST) begin
          nxt_rc = repeat_counter_ff - 16'h0001;
        end
        if (repeat_counter_ff == 16'h0001) begin
          nxt_st = ST_IDLE;
          nxt_ra = 1'b0;
          nxt_pc = pc_ff + `RCE_PC_STEP;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  // -----------------------------
  // registers
  // -----------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= ST_IDLE;
      pc_ff <= `RCE_PC_RST;
      sp_ff <= `RCE_SP_RST;
      repeat_counter_ff <= `RCE_RC_RST;
      repeat_active_flag_ff <= 1'b0;
      stack_frame_active_flag_ff <= 1'b0;
      software_reset_flag_ff <= 1'b0;
      stack_we_ff <= 1'b0;
      stack_addr_ff <= 16'h0000;
      stack_wdata_ff <= 16'h0000;
      ireg_ff <= `RCE_NOP;
      target_exec_ff <= 1'b0;
      ret_ff <= 23'h000000;
      tgt_ff <= 23'h000000;
      sfa_seen_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      repeat_counter_ff <= nxt_rc;
      repeat_active_flag_ff <= nxt_ra;
      stack_frame_active_flag_ff <= nxt_sfa;
      software_reset_flag_ff <= nxt_swr;
      stack_we_ff <= nxt_we;
      stack_addr_ff <= nxt_addr;
      stack_wdata_ff <= nxt_wdata;
      ireg_ff <= nxt_ireg;
      target_exec_ff <= nxt_tx;
      ret_ff <= nxt_ret;
      tgt_ff <= nxt_tgt;
      sfa_seen_ff <= nxt_sfa_seen;
    end
  end
endmodule // rce_exec
`default_nettype wire

/* File: tb/rce_exec_props.sv */
/*
  Port-level checker for rce_exec: call push, call target, repeat load, reset.
  Assumes one clock domain and the base opcode set; bound to every rce_exec.
*/
`timescale 1ns/10ps
`default_nettype none
module rce_exec_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [23:0] instr_in,
  input wire logic [15:0] reg_rdata,
  input wire logic [22:0] pc_ff,
  input wire logic [15:0] sp_ff,
  input wire logic [15:0] repeat_counter_ff,
  input wire logic repeat_active_flag_ff,
  input wire logic software_reset_flag_ff,
  input wire logic stack_we_ff,
  input wire logic [15:0] stack_addr_ff,
  input wire logic [15:0] stack_wdata_ff,
  input wire logic [23:0] ireg_ff,
  input wire logic target_exec_ff,
  input wire logic busy
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // a request only counts when the core is idle
  wire tk = instr_valid && !busy;
  wire call = tk && instr_in[23:4] == 20'h01200;
  wire repl = tk && instr_in[23:14] == 10'h024;
  property p_push;
    call |=> stack_we_ff && stack_addr_ff == $past(sp_ff)
      && stack_wdata_ff == $past(pc_ff[15:0]) + 16'h0002;
  endproperty
  a_push: assert property (p_push) else $error("call push wrong");
  property p_tgt;
    call |=> ##1 pc_ff == $past(pc_ff, 2) + 23'h000002
      + {{6{$past(reg_rdata[15], 2)}}, $past(reg_rdata, 2), 1'b0};
  endproperty
  a_tgt: assert property (p_tgt) else $error("call target wrong");
  property p_sp;
    call |=> stack_we_ff ##1 stack_we_ff && sp_ff == $past(sp_ff, 2) + 16'h0004;
  endproperty
  a_sp: assert property (p_sp) else $error("call stack step wrong");
  property p_lit;
    repl && instr_in[13:0] != 14'h0000 |=> repeat_active_flag_ff
      && repeat_counter_ff == {2'h0, $past(instr_in[13:0])} && pc_ff == $past(pc_ff) + 23'h2;
  endproperty
  a_lit: assert property (p_lit) else $error("literal repeat load wrong");
  property p_zero;
    repl && instr_in[13:0] == 14'h0000 |=> !repeat_active_flag_ff && !busy;
  endproperty
  a_zero: assert property (p_zero) else $error("zero repeat not a no-op");
  property p_reg;
    tk && instr_in[23:4] == 20'h09800 |=> repeat_counter_ff == {2'h0, $past(reg_rdata[13:0])};
  endproperty
  a_reg: assert property (p_reg) else $error("register repeat load wrong");
  property p_hold;
    target_exec_ff && $past(target_exec_ff) |-> $stable(ireg_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("target refetched");
  property p_rst;
    tk && instr_in == 24'hFE0000 |=> pc_ff == 23'h0 && sp_ff == 16'h0800
      && software_reset_flag_ff && !repeat_active_flag_ff && repeat_counter_ff == 16'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("software reset wrong");
  c_call: cover property (call);
  c_loop: cover property (repeat_active_flag_ff && target_exec_ff);
  c_rst: cover property (software_reset_flag_ff);
endmodule // rce_exec_chk
bind rce_exec rce_exec_chk u_rce_exec_chk (.clk, .nrst, .instr_valid, .instr_in, .reg_rdata,
  .pc_ff, .sp_ff, .repeat_counter_ff, .repeat_active_flag_ff, .software_reset_flag_ff,
  .stack_we_ff, .stack_addr_ff, .stack_wdata_ff, .ireg_ff, .target_exec_ff, .busy);
`default_nettype wire

/* File: tb/test_repeat_and_computed_call_exec.sv */
/*
  Directed bench for rce_exec, base variant.
  Assumes the bench plays fetch unit and register file on the ports.
*/
`timescale 1ns/10ps
`default_nettype none
module test_repeat_and_computed_call_exec;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  logic [23:0] instr_in = 24'h000000;
  logic [15:0] reg_rdata = 16'h0000;
  wire [22:0] pc_ff;
  wire [15:0] sp_ff, repeat_counter_ff, stack_addr_ff, stack_wdata_ff;
  wire [23:0] ireg_ff;
  wire repeat_active_flag_ff, software_reset_flag_ff, stack_we_ff, target_exec_ff, busy;
  wire [3:0] reg_sel;
  wire fetch_hold, stack_frame_active_flag_ff;
  logic [22:0] p = 23'h0;
  int err_count = 0;
  int checked = 0;
  rce_exec #(.EXT(1'b0)) u_rce_exec (.clk, .nrst, .instr_valid, .instr_in, .reg_rdata,
    .sfa_in(1'b0), .reg_sel, .pc_ff, .sp_ff, .repeat_counter_ff, .repeat_active_flag_ff,
    .stack_frame_active_flag_ff, .software_reset_flag_ff, .stack_we_ff, .stack_addr_ff,
    .stack_wdata_ff, .ireg_ff, .target_exec_ff, .fetch_hold, .busy);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always #10 clk = ~clk;
  task tick; begin @(posedge clk); #1; end endtask
  task chk(input logic [31:0] s, input logic [31:0] e); begin
    checked++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  end endtask
  // one-cycle request, data held to the taking edge
  task issue(input logic [23:0] w, input logic [15:0] r); begin
    instr_in = w; reg_rdata = r; instr_valid = 1'b1; tick; instr_valid = 1'b0;
  end endtask
  task test_done; begin
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  end endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // negative offset, so the sign extension is exercised
  task t_call; logic [22:0] ret; begin
    ret = p + 23'h2;
    // first stacked word is visible right after the taking edge
    issue({20'h01200, 4'h2}, 16'hFFC0);
    chk(reg_sel, 4'h2);
    chk(stack_we_ff, 1); chk(stack_addr_ff, 16'h0800); chk(stack_wdata_ff, ret[15:0]);
    tick; chk(stack_we_ff, 1); chk(stack_wdata_ff, {9'h0, ret[22:16]});
    p = ret + {6'h3F, 16'hFFC0, 1'b0};
    chk(pc_ff, p); chk(sp_ff, 16'h0804);
    chk(stack_frame_active_flag_ff, 0);
  end endtask
  // loop length must come out as count plus one
  task t_rep(input logic [23:0] w, input logic [15:0] r, input int n); int c, g; begin
    issue(w, r); tick;
    chk(repeat_counter_ff, n); chk(repeat_active_flag_ff, n != 0);
    p = p + 23'h2; chk(pc_ff, p);
    if (n != 0) begin
      // plain one-word, non-branching target, as software must supply
      issue(24'h0A5A5A, 16'h0000); c = target_exec_ff; g = 0;
      chk(fetch_hold, 1);
      while (busy === 1'b1 && g < 400) begin tick; c += target_exec_ff; g++; end
      chk(c, n + 1); chk(ireg_ff, 24'h0A5A5A);
      p = p + 23'h2; chk(pc_ff, p); chk(repeat_active_flag_ff, 0);
    end
  end endtask
  task t_reset; begin
    issue(24'hFE0000, 16'h0000); tick;
    chk(pc_ff, 0); chk(sp_ff, 16'h0800); chk(software_reset_flag_ff, 1);
    chk(repeat_active_flag_ff, 0); chk(repeat_counter_ff, 0);
  end endtask
  initial begin #100000; err_count++; test_done; end
  initial begin
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    t_call;
    t_rep({10'h024, 14'd3}, 16'h0000, 3);
    t_rep({10'h024, 14'd0}, 16'h0000, 0);
    t_rep({20'h09800, 4'h4}, 16'hC0FF, 255);
    t_reset;
    test_done;
  end
endmodule // test_repeat_and_computed_call_exec
`default_nettype wire
